// [rtl/tas_pkg.sv]
package tas_pkg;
  localparam int unsigned CLK_PERIOD_PS  = 5000;
  localparam int unsigned DEF_INTERVAL_PS = 15600000;
  // Nearest whole tick: 3120 cycles
  localparam int unsigned DEF_INTERVAL_CYC = (DEF_INTERVAL_PS + CLK_PERIOD_PS / 2) / CLK_PERIOD_PS;
  localparam int unsigned DEF_POINTS     = 2048;
  localparam int unsigned LOW_RANGE_UA   = 20000;
  localparam int unsigned MAX_POINTS     = 4096;
  // Register byte offsets
  localparam logic [7:0] A_CMD    = 8'h00;
  localparam logic [7:0] A_CFG    = 8'h04;
  localparam logic [7:0] A_INTVL  = 8'h08;
  localparam logic [7:0] A_POINTS = 8'h0C;
  localparam logic [7:0] A_VIMM   = 8'h10;
  localparam logic [7:0] A_VTRG   = 8'h14;
  localparam logic [7:0] A_IIMM   = 8'h18;
  localparam logic [7:0] A_ITRG   = 8'h1C;
  localparam logic [7:0] A_STATUS = 8'h20;
  localparam logic [7:0] A_QUERY  = 8'h24;
  localparam logic [7:0] A_RESULT = 8'h28;
  localparam logic [7:0] A_ARRAY  = 8'h2C;
  localparam logic [7:0] A_COUNT  = 8'h30;
  // Command register bits (write one to act)
  localparam int C_TRIG_IMM = 0;
  localparam int C_TRG_COM  = 1;
  localparam int C_GET      = 2;
  localparam int C_INIT_OUT = 3;
  localparam int C_INIT_MEAS = 4;
  localparam int C_ABORT    = 5;
  localparam int C_RESET    = 6;
  localparam int C_RECALL   = 7;
  // Config bits
  localparam int F_CONT_OUT = 0;
  localparam int F_FUNC_CUR = 1;
  localparam int F_SRC_INT  = 2;
  localparam int F_RANGE_LO = 3;
  // Query code field
  typedef enum logic [2:0] {
    TAS_Q_DC = 3'h0, TAS_Q_RMS = 3'h1, TAS_Q_MAX = 3'h2, TAS_Q_MIN = 3'h3, TAS_Q_ARR = 3'h4
  } tas_query_e;
  typedef struct packed {
    logic       meas;     // Measure (fresh acquisition) versus fetch
    logic       cur;      // Quantity asked for
    tas_query_e kind;
  } tas_query_s;
  typedef struct packed {
    logic [15:0] vtrg;
    logic [15:0] itrg;
  } tas_levels_s;
endpackage : tas_pkg

// [rtl/tas_sample_mem.sv]
`timescale 1ns/1ps
module tas_sample_mem #(
  parameter int unsigned DEPTH = 4096,
  parameter int unsigned WIDTH = 16
) (
  // Clock
  input  wire logic                     pclk,
  // Write port
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input  wire logic [WIDTH-1:0]         wr_data,
  // Registered read port
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic      [WIDTH-1:0]         rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  // Plain array, read data leaves a register
  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule : tas_sample_mem

// [rtl/tas_hann_rom.sv]
`timescale 1ns/1ps
module tas_hann_rom #(
  parameter int unsigned AW = 12
) (
  // Clock
  input  wire logic          pclk,
  // Phase in, weight out (Q0.9)
  input  wire logic [AW-1:0] phase,
  output logic      [8:0]    weight
);
  import tas_pkg::*;
  logic [AW-1:0] fold;
  logic [AW-1:0] t;

  // Triangle-squared shape approximating 0.5-0.5cos; cheap, no table file
  always_comb begin
    fold = phase[AW-1] ? ~phase : phase;
    t    = {fold[AW-2:0], 1'b0};
  end

  always_ff @(posedge pclk) begin
    weight <= 9'(({1'b0, t[AW-1:AW-8]} * {1'b0, t[AW-1:AW-8]}) >> 7);
  end
endmodule : tas_hann_rom

// [rtl/tas_sequencer.sv]
`timescale 1ns/1ps
module tas_sequencer #(
  parameter int unsigned SW        = 16,
  parameter int unsigned DEPTH     = tas_pkg::MAX_POINTS,
  parameter int unsigned INTERVAL0 = tas_pkg::DEF_INTERVAL_CYC,
  parameter int unsigned POINTS0   = tas_pkg::DEF_POINTS
) (
  // Clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Converter samples and internal trigger
  input  wire logic [SW-1:0]       volt_sample,
  input  wire logic [SW-1:0]       curr_sample,
  input  wire logic                output_edge_trig,
  // Output levels, change strobe and range select to the power stage; completion flag
  output tas_pkg::tas_levels_s     levels,
  output logic                     output_change,
  output logic                     meas_range_low,
  output logic                     op_complete
);
  import tas_pkg::*;
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH > MAX_POINTS || DEPTH < 2 || SW > 16) begin
      $error("tas_sequencer: unsupported DEPTH or SW");
    end
  end

  typedef enum logic [2:0] {OS_IDLE = 3'b001, OS_INIT = 3'b010, OS_CHANGE = 3'b100} tas_out_e;
  typedef enum logic [3:0] {MS_IDLE = 4'b0001, MS_INIT = 4'b0010, MS_FILL = 4'b0100, MS_CALC = 4'b1000} tas_meas_e;

  function automatic logic [AW:0] clip_pts(input logic [31:0] v);
    clip_pts = (v == 32'h0 || v > 32'(DEPTH)) ? (AW+1)'(DEPTH) : v[AW:0];
  endfunction : clip_pts

  tas_out_e          ostate;
  tas_meas_e         mstate;
  logic [3:0]        cfg;
  logic [19:0]       interval;
  logic [AW:0]       points;
  logic [15:0]       vimm, iimm, acq_count, acq_left;
  logic              vtrg_set, itrg_set;
  tas_levels_s       trg_lv;
  logic              wr, rd, bus_trig, meas_trig, last_cur, data_ok, q_busy, result_valid;
  logic [31:0]       cmd;
  tas_query_s        q;
  logic [19:0]       tick;
  logic [AW:0]       idx, base, cidx;
  logic [AW:0]       total;
  logic [SW-1:0]     rdata;
  logic [8:0]        w;
  logic [47:0]       wsum, sqsum;
  logic [SW-1:0]     vmax, vmin;
  logic [31:0]       result;
  logic [1:0]        pipe;

  assign wr  = psel && penable && pwrite;
  assign rd  = psel && penable && !pwrite;
  assign cmd = (wr && paddr == A_CMD) ? pwdata : 32'h0;
  // Three bus trigger forms collapse to one event
  assign bus_trig = cmd[C_TRIG_IMM] | cmd[C_TRG_COM] | cmd[C_GET];
  // Source selects bus or internal
  assign meas_trig = cfg[F_SRC_INT] ? output_edge_trig : bus_trig;
  assign meas_range_low = cfg[F_RANGE_LO]; // Low range is 20 mA scale
  // Busy query stalls the bus until its answer exists
  // Array reads never stall; each read simply takes the next stored sample
  assign pready  = !(psel && penable && !pwrite && paddr == A_RESULT && q_busy && q.kind != TAS_Q_ARR);
  assign pslverr = 1'b0;

  // Configuration and levels; reset restores defaults, but the reset command keeps vimm and iimm
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= 4'h0; interval <= 20'(INTERVAL0); points <= (AW+1)'(POINTS0);
      vimm <= 16'h0; iimm <= 16'h0; acq_count <= 16'h1;
      vtrg_set <= 1'b0; itrg_set <= 1'b0; trg_lv <= '0;
    end else if (cmd[C_RESET]) begin
      cfg <= 4'h0; interval <= 20'(INTERVAL0); points <= (AW+1)'(POINTS0);
      acq_count <= 16'h1; vtrg_set <= 1'b0; itrg_set <= 1'b0;
    end else if (wr) begin
      unique case (paddr)
        A_CFG:    cfg <= pwdata[3:0];
        A_INTVL:  interval <= (pwdata[19:0] == 20'h0) ? 20'h1 : pwdata[19:0]; // Ticks, rounded by host
        A_POINTS: points <= clip_pts(pwdata);
        A_VIMM:   vimm <= pwdata[15:0];
        A_IIMM:   iimm <= pwdata[15:0];
        A_VTRG:   begin trg_lv.vtrg <= pwdata[15:0]; vtrg_set <= 1'b1; end
        A_ITRG:   begin trg_lv.itrg <= pwdata[15:0]; itrg_set <= 1'b1; end
        A_COUNT:  acq_count <= (pwdata[15:0] == 16'h0) ? 16'h1 : pwdata[15:0];
        default:  ;
      endcase
    end
  end

  // Output-change sequence, bus triggers only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ostate <= OS_IDLE;
    end else if (cmd[C_ABORT] || cmd[C_RESET] || cmd[C_RECALL]) begin
      ostate <= OS_IDLE;
    end else begin
      unique case (ostate)
        OS_IDLE:   if (cmd[C_INIT_OUT] || cfg[F_CONT_OUT]) ostate <= OS_INIT;
        OS_INIT:   if (bus_trig) ostate <= OS_CHANGE;
        OS_CHANGE: ostate <= cfg[F_CONT_OUT] ? OS_INIT : OS_IDLE;
      endcase
    end
  end

  // Levels applied in the change state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      levels <= '0;
      output_change <= 1'b0;
    end else begin
      output_change <= (ostate == OS_CHANGE);
      if (ostate == OS_CHANGE) begin
        levels.vtrg <= vtrg_set ? trg_lv.vtrg : vimm;
        levels.itrg <= itrg_set ? trg_lv.itrg : iimm;
      end else if (wr && paddr == A_VIMM) begin
        // Immediate writes move the output outside the change state, overwriting a finished change's level
        levels.vtrg <= pwdata[15:0];
      end else if (wr && paddr == A_IIMM) begin
        levels.itrg <= pwdata[15:0];
      end
    end
  end

  // Measurement sequence; no continuous mode exists
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mstate <= MS_IDLE;
      acq_left <= 16'h0; last_cur <= 1'b0; data_ok <= 1'b0; base <= '0;
    end else if (cmd[C_ABORT] || cmd[C_RESET] || cmd[C_RECALL]) begin
      mstate <= MS_IDLE;
    end else begin
      unique case (mstate)
        MS_IDLE: if (cmd[C_INIT_MEAS]) begin
          mstate <= MS_INIT; acq_left <= acq_count; base <= '0;
        end else if (wr && paddr == A_QUERY && pwdata[5]) begin // Measure starts at once
          mstate <= MS_FILL; acq_left <= 16'h1; base <= '0; data_ok <= 1'b0;
          last_cur <= pwdata[4];
        end
        MS_INIT: if (meas_trig) begin
          mstate <= MS_FILL; data_ok <= 1'b0; last_cur <= cfg[F_FUNC_CUR];
        end
        MS_FILL: if (tick == 20'h0 && idx == base + points - 1'b1) begin // Retriggers ignored here
          acq_left <= acq_left - 16'h1;
          base <= base + points;
          if (acq_left > 16'h1 && base + 2*points <= (AW+1)'(DEPTH)) mstate <= MS_INIT;
          else begin mstate <= MS_IDLE; data_ok <= 1'b1; end
        end
        MS_CALC: mstate <= MS_IDLE;
      endcase
    end
  end

  assign op_complete = (ostate == OS_IDLE) && (mstate == MS_IDLE);

  // Interval counter and write index
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick <= 20'h0; idx <= '0;
    end else if (mstate != MS_FILL) begin
      tick <= 20'h0; idx <= base;
    end else if (tick == 20'h0) begin
      tick <= interval - 20'h1;
      idx <= idx + 1'b1;
    end else begin
      tick <= tick - 20'h1;
    end
  end

  tas_sample_mem #(.DEPTH(DEPTH), .WIDTH(SW)) u_mem (
    .pclk    (pclk),
    .wr_en   (mstate == MS_FILL && tick == 20'h0),
    .wr_addr (idx[AW-1:0]),
    .wr_data (last_cur ? curr_sample : volt_sample), // One quantity only
    .rd_addr (cidx[AW-1:0]),
    .rd_data (rdata)
  );

  tas_hann_rom #(.AW(AW)) u_win (
    .pclk   (pclk),
    .phase  (AW'(((2*AW+2)'(cidx) * (2*AW+2)'(DEPTH) / (2*AW+2)'(total == '0 ? (AW+1)'(1) : total)))),
    .weight (w)
  );

  // Query engine: walks buffer once all samples stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0; q_busy <= 1'b0; result_valid <= 1'b0; cidx <= '0; pipe <= 2'b0; total <= '0;
      wsum <= 48'h0; sqsum <= 48'h0; vmax <= '0; vmin <= '1; result <= 32'h0;
    end else if (wr && paddr == A_QUERY) begin
      q <= '{meas: pwdata[5], cur: pwdata[4], kind: tas_query_e'(pwdata[2:0])};
      q_busy <= 1'b1; result_valid <= 1'b0; cidx <= '0; pipe <= 2'b0; total <= base;
      wsum <= 48'h0; sqsum <= 48'h0; vmax <= '0; vmin <= '1;
    end else if (q_busy && q.kind == TAS_Q_ARR) begin
      // Array: one sample per result read, in order
      if (data_ok && rd && paddr == A_RESULT) cidx <= cidx + 1'b1;
      result <= {16'h0, rdata};
      result_valid <= data_ok;
    end else if (q_busy && data_ok && mstate == MS_IDLE) begin
      total <= base;
      if (q.cur != last_cur) begin // Wrong quantity refused
        result <= 32'hFFFF_FFFF; q_busy <= 1'b0;
      end else if (pipe != 2'b00 || cidx != total) begin
        if (cidx != total) cidx <= cidx + 1'b1;
        pipe <= {pipe[0], cidx != total};
        // Read data lags the index by one register stage
        if (pipe[0]) begin
          wsum  <= wsum + 48'(rdata * w); // Window weight then sum
          sqsum <= sqsum + 48'((32'(rdata) * rdata >> 8) * w);
          if (rdata > vmax) vmax <= rdata;
          if (rdata < vmin) vmin <= rdata;
        end
        if (pipe == 2'b10 && cidx == total) begin
          q_busy <= 1'b0;
          unique case (q.kind)
            TAS_Q_DC:  result <= 32'(wsum / (48'(total) * 48'd128));
            TAS_Q_RMS: result <= 32'(sqsum / (48'(total) * 48'd128));
            TAS_Q_MAX: result <= 32'(vmax);
            TAS_Q_MIN: result <= 32'(vmin);
            default:   result <= 32'h0;
          endcase
        end
      end
    end
  end

  // Read mux, unmapped addresses read zero
  always_comb begin
    unique case (paddr)
      A_CFG:    prdata = {28'h0, cfg};
      A_INTVL:  prdata = {12'h0, interval};
      A_POINTS: prdata = 32'(points);
      A_VIMM:   prdata = {16'h0, vimm};
      A_VTRG:   prdata = {16'h0, vtrg_set ? trg_lv.vtrg : vimm};
      A_IIMM:   prdata = {16'h0, iimm};
      A_ITRG:   prdata = {16'h0, itrg_set ? trg_lv.itrg : iimm};
      A_STATUS: prdata = {23'h0, last_cur, data_ok, q_busy, op_complete, mstate, 1'b0};
      A_RESULT: prdata = result;
      A_COUNT:  prdata = {16'h0, acq_count};
      default:  prdata = 32'h0;
    endcase
  end

  idle_ignores_trig_a: assert property (@(posedge pclk) disable iff (!presetn)
    mstate == MS_IDLE && !cmd[C_INIT_MEAS] && !(wr && paddr == A_QUERY) |=> mstate != MS_FILL)
    else $error("trigger taken while idle");
  abort_to_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    cmd[C_ABORT] |=> mstate == MS_IDLE && ostate == OS_IDLE)
    else $error("abort did not idle");
  opc_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    op_complete |-> mstate == MS_IDLE)
    else $error("opc true while armed");
  out_change_a: assert property (@(posedge pclk) disable iff (!presetn)
    ostate == OS_INIT && bus_trig && !cmd[C_ABORT] && !cmd[C_RESET] && !cmd[C_RECALL]
      |=> ostate == OS_CHANGE ##1 output_change)
    else $error("output change missed");
  cont_rearm_a: assert property (@(posedge pclk) disable iff (!presetn)
    ostate == OS_CHANGE && cfg[F_CONT_OUT] && cmd == 32'h0 |=> ostate == OS_INIT)
    else $error("continuous not rearmed");
  reset_defaults_a: assert property (@(posedge pclk) disable iff (!presetn)
    cmd[C_RESET] |=> interval == 20'(INTERVAL0) && points == (AW+1)'(POINTS0))
    else $error("reset defaults wrong");
  fill_quantity_a: assert property (@(posedge pclk) disable iff (!presetn)
    mstate == MS_FILL |=> mstate != MS_FILL || $stable(last_cur))
    else $error("quantity changed mid acquisition");
  no_retrigger_a: assert property (@(posedge pclk) disable iff (!presetn)
    mstate == MS_FILL && tick != 20'h0 |=> mstate == MS_FILL || mstate == MS_IDLE)
    else $error("fill disturbed");
endmodule : tas_sequencer

// [tb/tas_host_model.sv]
`timescale 1ns/1ps
module tas_host_model
  import tas_pkg::*;
(
  // Clock
  input  wire logic        pclk,
  // APB master
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready
);
  // Bus quiet until the bench asks for a transfer
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end

  // One transfer; waits as long as the slave stalls, the bench watchdog ends a hang
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released lines show garbage, never the last value
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask : xfer

  // Immediate, common and group triggers go the same way
  task automatic trigger(input int k);
    logic [31:0] r;
    xfer(1'b1, A_CMD, 32'h1 << k, r);
  endtask : trigger
endmodule : tas_host_model

// [tb/trigger_and_acquisition_sequencer_test.sv]
`timescale 1ns/1ps
module trigger_and_acquisition_sequencer_test;
  import tas_pkg::*;
  localparam int unsigned IV = 4;
  localparam int unsigned NP = 8;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        output_change, meas_range_low, op_complete, output_edge_trig;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] volt_sample, curr_sample, sv, sc;
  tas_levels_s levels;
  int          n_errors = 0;
  int          total_checks = 0;
  int          n_chg = 0;
  int          cycles = 0;
  logic [31:0] seed = 32'h62;

  tas_sequencer #(.SW(16), .DEPTH(16), .INTERVAL0(IV), .POINTS0(NP)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .volt_sample(volt_sample), .curr_sample(curr_sample), .output_edge_trig(output_edge_trig),
    .levels(levels), .output_change(output_change), .meas_range_low(meas_range_low),
    .op_complete(op_complete));

  tas_host_model host (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready));

  initial pclk = 1'b0;
  always #2.5 pclk = ~pclk;

  // Count output change pulses
  always @(posedge pclk) if (output_change === 1'b1) n_chg++;

  // Watchdog, far above the thousand or so cycles the run needs
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rd);
    // Let the state the write caused settle before anyone looks
    @(negedge pclk);
  endtask : wr

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    host.xfer(1'b0, a, 32'h0, rd);
    check(nm, rd, exp);
  endtask : rdchk

  // Bounded wait for both sequences idle, then let registered outputs land
  task automatic wait_idle();
    for (int i = 0; i < 2000 && op_complete !== 1'b1; i++) @(posedge pclk);
    repeat (3) @(posedge pclk);
  endtask : wait_idle

  task automatic ask(input string nm, input logic m, input logic cu, input tas_query_e kd,
                     input logic [31:0] exp);
    tas_query_s q;
    q.meas = m;
    q.cur  = cu;
    q.kind = kd;
    wr(A_QUERY, {26'h0, q.meas, q.cur, 1'b0, q.kind});
    rdchk(nm, A_RESULT, exp);
  endtask : ask

  // Fresh random converter values, held steady through an acquisition
  task automatic smp();
    seed = xs(seed);
    sv   = {1'b0, seed[14:0]};
    seed = xs(seed);
    sc   = {1'b0, seed[14:0]};
    @(posedge pclk);
    volt_sample <= sv;
    curr_sample <= sc;
  endtask : smp

  initial begin
    logic [15:0] ov, oc, tv;
    logic        cu;
    presetn = 1'b0;
    volt_sample = 16'h0;
    curr_sample = 16'h0;
    output_edge_trig = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("interval", A_INTVL, IV);
    rdchk("points", A_POINTS, NP);
    rdchk("unmapped", 8'h3C, 32'h0);
    host.trigger(C_TRIG_IMM);
    repeat (4) @(posedge pclk);
    check("idle opc", {31'h0, op_complete}, 32'h1);
    host.xfer(1'b0, A_STATUS, 32'h0, rd);
    check("idle data", {31'h0, rd[7]}, 32'h0);
    // Output sequence through every bus trigger kind
    smp();
    tv = sv ^ 16'h1234;
    wr(A_VIMM, {16'h0, sv});
    wr(A_IIMM, {16'h0, sc});
    wr(A_VTRG, {16'h0, tv});
    for (int k = 0; k < 3; k++) begin
      wr(A_CMD, 32'h1 << C_INIT_OUT);
      check("armed opc", {31'h0, op_complete}, 32'h0);
      host.trigger(k);
      wait_idle();
      check("volt level", {16'h0, levels.vtrg}, {16'h0, tv});
      check("curr level", {16'h0, levels.itrg}, {16'h0, sc});
      check("changes", 32'(n_chg), k + 1);
    end
    // Internal edge must not fire the output sequence
    wr(A_CFG, 32'h1 << F_SRC_INT);
    wr(A_CMD, 32'h1 << C_INIT_OUT);
    @(posedge pclk) output_edge_trig <= 1'b1;
    @(posedge pclk) output_edge_trig <= 1'b0;
    repeat (4) @(posedge pclk);
    check("edge ignored", 32'(n_chg), 32'h3);
    // Continuous: one initiate, two changes
    wr(A_CFG, 32'h1 << F_CONT_OUT);
    host.trigger(C_GET);
    repeat (4) @(posedge pclk);
    host.trigger(C_TRG_COM);
    repeat (4) @(posedge pclk);
    check("continuous", 32'(n_chg), 32'h5);
    wr(A_CFG, 32'h0);
    wr(A_INTVL, 32'h6);
    wr(A_CMD, 32'h1 << C_RESET);
    wait_idle();
    rdchk("interval rst", A_INTVL, IV);
    // Measure and fetch for each quantity
    for (int i = 0; i < 2; i++) begin
      cu = i[0];
      smp();
      ov = cu ? sc : sv;
      ask("meas max", 1'b1, cu, TAS_Q_MAX, {16'h0, ov});
      ask("meas min", 1'b1, cu, TAS_Q_MIN, {16'h0, ov});
      host.xfer(1'b0, A_STATUS, 32'h0, rd);
      check("quantity", {31'h0, rd[8]}, {31'h0, cu});
      ask("other", 1'b0, ~cu, TAS_Q_MAX, 32'hFFFFFFFF);
      smp();
      ask("fetch max", 1'b0, cu, TAS_Q_MAX, {16'h0, ov});
      wr(A_QUERY, {26'h0, 1'b0, cu, 1'b0, TAS_Q_ARR});
      for (int j = 0; j < NP; j++) rdchk("array", A_RESULT, {16'h0, ov});
    end
    // Triggered voltage acquisitions, each bus trigger kind
    wr(A_COUNT, 32'h1);
    for (int k = 0; k < 3; k++) begin
      smp();
      wr(A_CMD, 32'h1 << C_INIT_MEAS);
      check("meas armed", {31'h0, op_complete}, 32'h0);
      host.trigger(k);
      wait_idle();
      check("meas done", {31'h0, op_complete}, 32'h1);
      ask("trig max", 1'b0, 1'b0, TAS_Q_MAX, {16'h0, sv});
    end
    wr(A_CMD, 32'h1 << C_INIT_MEAS);
    wr(A_CMD, 32'h1 << C_ABORT);
    repeat (2) @(posedge pclk);
    check("abort", {31'h0, op_complete}, 32'h1);
    // Internal source, current quantity
    wr(A_CFG, (32'h1 << F_SRC_INT) | (32'h1 << F_FUNC_CUR));
    smp();
    oc = sc;
    wr(A_CMD, 32'h1 << C_INIT_MEAS);
    @(posedge pclk) output_edge_trig <= 1'b1;
    @(posedge pclk) output_edge_trig <= 1'b0;
    wait_idle();
    ask("internal", 1'b0, 1'b1, TAS_Q_MIN, {16'h0, oc});
    wr(A_CFG, 32'h1 << F_RANGE_LO);
    @(posedge pclk);
    check("low range", {31'h0, meas_range_low}, 32'h1);
    tally_and_finish();
  end
endmodule : trigger_and_acquisition_sequencer_test
